// ---- sbt_pkg.sv ----
// Shared constants for the sixteen-bit general timer
package sbt_pkg;
    localparam int SBT_AW = 5;
    localparam int SBT_DW = 32;
    localparam int SBT_CW = 16;
    // Register byte offsets
    localparam logic [SBT_AW-1:0] SBT_OFF_CONTROL = 5'h00;
    localparam logic [SBT_AW-1:0] SBT_OFF_PERIOD = 5'h04;
    localparam logic [SBT_AW-1:0] SBT_OFF_COUNT = 5'h08;
    localparam logic [SBT_AW-1:0] SBT_OFF_STATUS = 5'h0c;
    localparam logic [SBT_AW-1:0] SBT_OFF_CLEAR = 5'h10;
    localparam logic [SBT_AW-1:0] SBT_OFF_ENABLE = 5'h14;
    // Control field positions
    localparam int SBT_BIT_RUN = 15;
    localparam int SBT_BIT_IDLE_STOP = 13;
    localparam int SBT_BIT_GATE = 6;
    localparam int SBT_BIT_PS_HI = 5;
    localparam int SBT_BIT_PS_LO = 4;
    localparam int SBT_BIT_SYNC = 2;
    localparam int SBT_BIT_CS = 1;
    localparam logic [SBT_CW-1:0] SBT_CONTROL_MASK = 16'ha076;
    localparam logic [SBT_CW-1:0] SBT_CONTROL_RESET = 16'h0000;
    localparam logic [SBT_CW-1:0] SBT_PERIOD_RESET = 16'hffff;
    localparam logic [SBT_CW-1:0] SBT_COUNT_RESET = 16'h0000;
    // Interrupt event bits
    localparam int SBT_NIRQ = 2;
    localparam int SBT_IRQ_MATCH = 0;
    localparam int SBT_IRQ_GATE_FALL = 1;
    // Prescale codes and their terminal counts (ratio minus one)
    localparam logic [1:0] SBT_PS_1 = 2'h0;
    localparam logic [1:0] SBT_PS_8 = 2'h1;
    localparam logic [1:0] SBT_PS_64 = 2'h2;
    localparam logic [1:0] SBT_PS_256 = 2'h3;
    localparam int SBT_PW = 8;
    localparam logic [SBT_PW-1:0] SBT_TC_1 = 8'h00;
    localparam logic [SBT_PW-1:0] SBT_TC_8 = 8'h07;
    localparam logic [SBT_PW-1:0] SBT_TC_64 = 8'h3f;
    localparam logic [SBT_PW-1:0] SBT_TC_256 = 8'hff;
    typedef enum logic [2:0] {
        SBT_BUS_IDLE = 3'b001,
        SBT_BUS_WAIT = 3'b010,
        SBT_BUS_DONE = 3'b100
    } sbt_bus_t;
endpackage : sbt_pkg

// ---- sbt_prescaler.sv ----
// Prescaler turning count ticks into prescaled increment pulses
`timescale 1ns/1ps
`default_nettype none
module sbt_prescaler
    import sbt_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic clear,
    input wire logic tick,
    input wire logic [1:0] select,
    // Result
    output logic pulse
);
    logic [SBT_PW-1:0] acc;
    logic [SBT_PW-1:0] next_acc;
    logic [SBT_PW-1:0] limit;

    always_comb begin
        unique case (select)
            SBT_PS_1: limit = SBT_TC_1;
            SBT_PS_8: limit = SBT_TC_8;
            SBT_PS_64: limit = SBT_TC_64;
            SBT_PS_256: limit = SBT_TC_256;
        endcase
        pulse = tick && (acc == limit);
        if (clear) begin
            next_acc = '0;
        end else if (pulse) begin
            next_acc = '0;
        end else if (tick) begin
            next_acc = acc + 8'h01;
        end else begin
            next_acc = acc;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc <= '0;
        end else begin
            acc <= next_acc;
        end
    end
endmodule : sbt_prescaler
`default_nettype wire

// ---- sbt_timer.sv ----
// Sixteen-bit general timer with APB registers and interrupt
`timescale 1ns/1ps
`default_nettype none
module sbt_timer
    import sbt_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [SBT_AW-1:0] paddr,
    input wire logic [SBT_DW-1:0] pwdata,
    output logic [SBT_DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Power state of the processor
    input wire logic idle_mode,
    input wire logic sleep_mode,
    // Pin: external clock, also the gate
    input wire logic external_timer_clock_pin,
    // Interrupt
    output logic irq
);
    import sbt_pkg::*;

    logic [SBT_CW-1:0] timer_control;
    logic [SBT_CW-1:0] period_register;
    logic [SBT_CW-1:0] count;
    logic [SBT_NIRQ-1:0] irq_status;
    logic [SBT_NIRQ-1:0] irq_enable;
    logic [SBT_CW-1:0] next_timer_control;
    logic [SBT_CW-1:0] next_period_register;
    logic [SBT_CW-1:0] next_count;
    logic [SBT_NIRQ-1:0] next_irq_status;
    logic [SBT_NIRQ-1:0] next_irq_enable;
    logic [SBT_DW-1:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic next_irq;
    sbt_bus_t bus_state;
    sbt_bus_t next_bus_state;

    logic pin_meta;
    logic pin_sync;
    logic pin_prev;
    logic next_pin_prev;

    logic timer_run;
    logic idle_stop;
    logic gate_accumulate_enable;
    logic [1:0] prescale_select;
    logic external_sync_select;
    logic clock_source_select;
    logic running;
    logic gated;
    logic tick;
    logic inc;
    logic gate_fall;
    logic access;
    logic wr;
    logic mapped;
    logic ps_clear;
    logic [SBT_NIRQ-1:0] events;

    function automatic logic [SBT_DW-1:0] sbt_widen(
        input logic [SBT_CW-1:0] v
    );
        sbt_widen = {{(SBT_DW-SBT_CW){1'b0}}, v};
    endfunction : sbt_widen

    // Control fields
    assign timer_run = timer_control[SBT_BIT_RUN];
    assign idle_stop = timer_control[SBT_BIT_IDLE_STOP];
    assign gate_accumulate_enable = timer_control[SBT_BIT_GATE];
    assign prescale_select = timer_control[SBT_BIT_PS_HI:SBT_BIT_PS_LO];
    assign external_sync_select = timer_control[SBT_BIT_SYNC];
    assign clock_source_select = timer_control[SBT_BIT_CS];

    // Pin passes two flops before any logic reads it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
        end else begin
            pin_meta <= external_timer_clock_pin;
            pin_sync <= pin_meta;
        end
    end

    always_comb begin
        // Only the unsynchronised counter survives Sleep
        running = timer_run && !(idle_stop && idle_mode) &&
                  !(sleep_mode &&
                    !(clock_source_select && !external_sync_select));
        gated = gate_accumulate_enable && !clock_source_select;
        // Pin rising edge or instruction-rate clock
        // Sync bit only matters for the external source
        if (clock_source_select) begin
            tick = running && pin_sync && !pin_prev;
        end else if (gated) begin
            // Gate high lets internal ticks through
            tick = running && pin_sync;
        end else begin
            tick = running;
        end
        gate_fall = running && gated && pin_prev && !pin_sync;
        next_pin_prev = pin_sync;
    end

    // Control writes restart the prescaler so a new ratio starts clean
    assign ps_clear = wr &&
        (paddr == SBT_OFF_CONTROL || paddr == SBT_OFF_COUNT);

    sbt_prescaler u_prescaler (
        .pclk(pclk),
        .presetn(presetn),
        .clear(ps_clear),
        .tick(tick),
        .select(prescale_select),
        .pulse(inc)
    );

    // Bus decode: answer on the second access cycle
    assign access = psel && penable && (bus_state == SBT_BUS_WAIT);
    assign wr = access && pwrite;
    always_comb begin
        unique case (paddr)
            SBT_OFF_CONTROL, SBT_OFF_PERIOD, SBT_OFF_COUNT,
            SBT_OFF_STATUS, SBT_OFF_CLEAR, SBT_OFF_ENABLE: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    always_comb begin
        next_bus_state = bus_state;
        next_pready = 1'b0;
        next_pslverr = 1'b0;
        next_prdata = '0;
        unique case (bus_state)
            SBT_BUS_IDLE: begin
                if (psel && !penable) begin
                    next_bus_state = SBT_BUS_WAIT;
                end
            end
            SBT_BUS_WAIT: begin
                if (access) begin
                    next_bus_state = SBT_BUS_DONE;
                    next_pready = 1'b1;
                    next_pslverr = !mapped;
                    if (!pwrite) begin
                        unique case (paddr)
                            SBT_OFF_CONTROL:
                                next_prdata = sbt_widen(timer_control);
                            SBT_OFF_PERIOD:
                                next_prdata = sbt_widen(period_register);
                            SBT_OFF_COUNT:
                                next_prdata = sbt_widen(count);
                            SBT_OFF_STATUS:
                                next_prdata = {{(SBT_DW-SBT_NIRQ){1'b0}},
                                               irq_status};
                            SBT_OFF_ENABLE:
                                next_prdata = {{(SBT_DW-SBT_NIRQ){1'b0}},
                                               irq_enable};
                            default: next_prdata = '0;
                        endcase
                    end
                end else if (!psel) begin
                    next_bus_state = SBT_BUS_IDLE;
                end
            end
            SBT_BUS_DONE: begin
                next_bus_state = (psel && !penable) ? SBT_BUS_WAIT
                                                    : SBT_BUS_IDLE;
            end
            default: next_bus_state = SBT_BUS_IDLE;
        endcase
    end

    always_comb begin
        next_timer_control = timer_control;
        next_period_register = period_register;
        next_count = count;
        next_irq_enable = irq_enable;
        events = '0;
        // Wrap to zero on the increment after a match
        if (inc) begin
            if (count == period_register) begin
                next_count = '0;
            end else begin
                next_count = count + 16'h0001;
            end
        end
        events[SBT_IRQ_MATCH] = inc && (count == period_register);
        events[SBT_IRQ_GATE_FALL] = gate_fall;
        next_irq_status = irq_status;
        if (wr) begin
            unique case (paddr)
                SBT_OFF_CONTROL:
                    next_timer_control = pwdata[SBT_CW-1:0] &
                                         SBT_CONTROL_MASK;
                SBT_OFF_PERIOD: next_period_register = pwdata[SBT_CW-1:0];
                SBT_OFF_COUNT: next_count = pwdata[SBT_CW-1:0];
                SBT_OFF_CLEAR:
                    next_irq_status = irq_status & ~pwdata[SBT_NIRQ-1:0];
                SBT_OFF_ENABLE: next_irq_enable = pwdata[SBT_NIRQ-1:0];
                default: ;
            endcase
        end
        // Set wins over a clear in the same cycle
        next_irq_status = next_irq_status | events;
        next_irq = |(next_irq_status & next_irq_enable);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_control <= SBT_CONTROL_RESET;
            period_register <= SBT_PERIOD_RESET;
            count <= SBT_COUNT_RESET;
            irq_status <= '0;
            irq_enable <= '0;
            bus_state <= SBT_BUS_IDLE;
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            irq <= 1'b0;
            pin_prev <= 1'b0;
        end else begin
            timer_control <= next_timer_control;
            period_register <= next_period_register;
            count <= next_count;
            irq_status <= next_irq_status;
            irq_enable <= next_irq_enable;
            bus_state <= next_bus_state;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            irq <= next_irq;
            pin_prev <= next_pin_prev;
        end
    end
endmodule : sbt_timer
`default_nettype wire

// ---- sbt_pin_model.sv ----
// Far-side model of the external count clock and gate pin
`timescale 1ns/1ps
`default_nettype none
module sbt_pin_model (
    // Clock
    input wire logic pclk,
    // Control from the bench
    input wire logic run,
    input wire logic level,
    input wire logic [3:0] half,
    // Pin
    output logic pin
);
    logic [3:0] cnt = 4'h0;
    logic tog = 1'b0;
    always @(posedge pclk) begin
        cnt <= (cnt >= half) ? 4'h0 : cnt + 4'h1;
        if (!run)
            tog <= 1'b0;
        else if (cnt >= half)
            tog <= !tog;
    end
    // Outside a burst the pin sits at the gate level the bench asks for
    assign pin = run ? tog : level;
endmodule : sbt_pin_model
`default_nettype wire

// ---- sbt_timer_assertions.sv ----
// Port checker for the sixteen-bit general timer
`timescale 1ns/1ps
`default_nettype none
module sbt_timer_assertions
    import sbt_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [SBT_AW-1:0] paddr,
    input wire logic [SBT_DW-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Interrupt
    input wire logic irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic rd;
    assign rd = pready && !pwrite;
    ack_timing_a: assert property (psel && penable && !pready |=> pready)
        else $error("no answer one cycle into access");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    ready_access_a: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    idle_data_a: assert property (!pready |-> prdata == '0)
        else $error("read data outside answer");
    unmapped_err_a: assert property (pready && paddr[1:0] == 2'h0
        |-> pslverr == (paddr > SBT_OFF_ENABLE))
        else $error("error flag wrong for address");
    control_zero_a: assert property (rd && paddr == SBT_OFF_CONTROL
        |-> (prdata & ~{16'h0, SBT_CONTROL_MASK}) == '0)
        else $error("unused control bits read nonzero");
    status_width_a: assert property (rd && paddr == SBT_OFF_STATUS
        |-> prdata[31:2] == '0)
        else $error("status has extra bits");
    clear_zero_a: assert property (rd && paddr == SBT_OFF_CLEAR |-> prdata == '0)
        else $error("clear register read nonzero");
    cover property (pready && pslverr);
    cover property (rd && paddr == SBT_OFF_STATUS && prdata[0]);
    cover property ($rose(irq));
endmodule : sbt_timer_assertions
bind sbt_timer sbt_timer_assertions chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the sixteen-bit general timer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
    miscompares++; $display("wrong value %s expected %h seen %h", \
    nm, e, g); end end
module testbench;
    import sbt_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, idle_mode = 1'b0, sleep_mode = 1'b0;
    logic [4:0] paddr = 5'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, irq, pin, err, pin_q = 1'b0;
    logic pin_run = 1'b0, pin_lvl = 1'b0;
    logic [3:0] pin_half = 4'h0;
    int miscompares = 0, total_checks = 0, edges = 0;
    always #2.5 pclk = ~pclk;
    sbt_timer uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .idle_mode(idle_mode), .sleep_mode(sleep_mode),
        .external_timer_clock_pin(pin), .irq(irq));
    sbt_pin_model far_end (.pclk(pclk), .run(pin_run), .level(pin_lvl),
        .half(pin_half), .pin(pin));
    // Rising pin edges seen by the bench itself
    always @(posedge pclk) begin
        pin_q <= pin;
        if (pin && !pin_q)
            edges++;
    end
    task automatic results();
        $display("checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : results
    task automatic apb(input logic w, input logic [4:0] a,
        input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            miscompares++;
            results();
        end
    endtask : apb
    task automatic rdc(input logic [4:0] a, input logic [31:0] e,
        input string nm);
        apb(1'b0, a, 32'h0);
        `CHK(nm, e, q)
    endtask : rdc
    task automatic wait_irq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        // A missing interrupt ends the run through the closing report
        if (n >= 50) begin
            miscompares++;
            results();
        end
        `CHK("irq", 1'b1, irq)
    endtask : wait_irq
    task automatic t_regs();
        rdc(SBT_OFF_CONTROL, 32'h0, "control");
        rdc(SBT_OFF_PERIOD, 32'h0000ffff, "period");
        rdc(SBT_OFF_STATUS, 32'h0, "status");
        rdc(SBT_OFF_ENABLE, 32'h0, "enable");
        apb(1'b1, SBT_OFF_CONTROL, 32'hffffffff);
        rdc(SBT_OFF_CONTROL, 32'h0000a076, "control");
        apb(1'b1, SBT_OFF_CONTROL, 32'h0);
        rdc(5'h18, 32'h0, "unmapped");
        `CHK("slverr", 1'b1, err)
        $display("test registers done");
    endtask : t_regs
    task automatic t_match();
        logic [31:0] a;
        // Period and interrupt set up before the run bit
        apb(1'b1, SBT_OFF_PERIOD, 32'h2);
        apb(1'b1, SBT_OFF_ENABLE, 32'h1);
        apb(1'b1, SBT_OFF_CONTROL, 32'h8000);
        wait_irq();
        apb(1'b1, SBT_OFF_CONTROL, 32'h0);
        rdc(SBT_OFF_STATUS, 32'h1, "status");
        apb(1'b0, SBT_OFF_COUNT, 32'h0);
        a = q;
        `CHK("wrap", 1'b1, a <= 32'h2)
        repeat (10) @(posedge pclk);
        rdc(SBT_OFF_COUNT, a, "stopped count");
        apb(1'b1, SBT_OFF_CLEAR, 32'h1);
        repeat (2) @(posedge pclk);
        `CHK("irq", 1'b0, irq)
        $display("test match done");
    endtask : t_match
    task automatic t_prescale();
        int r;
        apb(1'b1, SBT_OFF_PERIOD, 32'hffff);
        for (int i = 0; i < 4; i++) begin
            r = (i == 0) ? 1 : (i == 1) ? 8 : (i == 2) ? 64 : 256;
            apb(1'b1, SBT_OFF_COUNT, 32'h0);
            apb(1'b1, SBT_OFF_CONTROL, 32'h8000 | (i << 4));
            repeat (1024) @(posedge pclk);
            apb(1'b1, SBT_OFF_CONTROL, 32'h0);
            apb(1'b0, SBT_OFF_COUNT, 32'h0);
            `CHK("ratio", 1'b1, q >= 1024 / r && q <= 1028 / r + 1)
        end
        $display("test prescale done");
    endtask : t_prescale
    task automatic t_idle();
        idle_mode <= 1'b1;
        apb(1'b1, SBT_OFF_COUNT, 32'h0);
        apb(1'b1, SBT_OFF_CONTROL, 32'ha000);
        repeat (40) @(posedge pclk);
        rdc(SBT_OFF_COUNT, 32'h0, "idle halt");
        apb(1'b1, SBT_OFF_CONTROL, 32'h8000);
        repeat (40) @(posedge pclk);
        apb(1'b0, SBT_OFF_COUNT, 32'h0);
        `CHK("idle run", 1'b1, q > 32'h20)
        idle_mode <= 1'b0;
        $display("test idle done");
    endtask : t_idle
    task automatic t_ext(input logic [31:0] c, input logic [3:0] h);
        pin_half <= h;
        apb(1'b1, SBT_OFF_COUNT, 32'h0);
        apb(1'b1, SBT_OFF_CONTROL, c);
        edges = 0;
        pin_run <= 1'b1;
        repeat (60) @(posedge pclk);
        pin_run <= 1'b0;
        repeat (10) @(posedge pclk);
        apb(1'b1, SBT_OFF_CONTROL, 32'h0);
        rdc(SBT_OFF_COUNT, edges, "pin edges");
    endtask : t_ext
    task automatic t_gate();
        apb(1'b1, SBT_OFF_ENABLE, 32'h2);
        apb(1'b1, SBT_OFF_COUNT, 32'h0);
        apb(1'b1, SBT_OFF_CONTROL, 32'h8040);
        pin_lvl <= 1'b1;
        repeat (40) @(posedge pclk);
        pin_lvl <= 1'b0;
        wait_irq();
        apb(1'b1, SBT_OFF_CONTROL, 32'h0);
        apb(1'b0, SBT_OFF_COUNT, 32'h0);
        `CHK("gated", 1'b1, q >= 37 && q <= 43)
        rdc(SBT_OFF_STATUS, 32'h2, "status");
        $display("test gate done");
    endtask : t_gate
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_match();
        t_prescale();
        t_idle();
        sleep_mode <= 1'b1;
        t_ext(32'h8002, 4'h0);
        sleep_mode <= 1'b0;
        t_ext(32'h8046, 4'h3);
        $display("test external done");
        t_gate();
        results();
    end
endmodule : testbench
`default_nettype wire
